// ==== rtl/mdx_defines.svh ====
`ifndef MDX_DEFINES_SVH
`define MDX_DEFINES_SVH
// ----------------------------------------
// widths, link register, divide cycles and reset values
// ----------------------------------------
`define MDX_XLEN 32
`define MDX_IMM_W 16
`define MDX_TGT_W 26
`define MDX_PC_HI_W 4
`define MDX_LINK_REG 5'h1f
`define MDX_DIV_CYCLES 32
`define MDX_HI_RST 32'h0000_0000
`define MDX_LO_RST 32'h0000_0000
`endif

// ==== rtl/mdx_pkg.sv ====
package mdx_pkg;
    typedef enum logic [5:0] {
        MDX_NOP = 6'h00,
        MDX_PRODUCT_SIGNED = 6'h01,
        MDX_PRODUCT_UNSIGNED = 6'h02,
        MDX_QUOTIENT_SIGNED = 6'h03,
        MDX_QUOTIENT_UNSIGNED = 6'h04,
        MDX_READ_UPPER_RESULT = 6'h05,
        MDX_READ_LOWER_RESULT = 6'h06,
        MDX_WRITE_UPPER_RESULT = 6'h07,
        MDX_WRITE_LOWER_RESULT = 6'h08,
        MDX_CIRCULAR_IMMEDIATE_SUM = 6'h09,
        MDX_FIRST_ONE_SCAN = 6'h0a,
        MDX_FIRST_ZERO_SCAN = 6'h0b,
        MDX_PAIR_SHIFT_TOWARD_LSB = 6'h0c,
        MDX_PAIR_SHIFT_TOWARD_MSB = 6'h0d,
        MDX_PRODUCT_ACCUMULATE_SIGNED = 6'h0e,
        MDX_PRODUCT_ACCUMULATE_UNSIGNED = 6'h0f,
        MDX_PRODUCT_DEDUCT_SIGNED = 6'h10,
        MDX_PRODUCT_DEDUCT_UNSIGNED = 6'h11,
        MDX_MINIMUM = 6'h12,
        MDX_MAXIMUM = 6'h13,
        MDX_ABSOLUTE_TRANSFER = 6'h14,
        MDX_ABSOLUTE_TRANSFER_WITH_LINK = 6'h15,
        MDX_REGISTER_TARGET_TRANSFER = 6'h16,
        MDX_REGISTER_TRANSFER_WITH_LINK = 6'h17,
        MDX_BRANCH_IF_SAME = 6'h18,
        MDX_BRANCH_IF_DIFFERENT = 6'h19,
        MDX_BRANCH_NONPOSITIVE = 6'h1a,
        MDX_BRANCH_POSITIVE = 6'h1b,
        MDX_BRANCH_NEGATIVE = 6'h1c,
        MDX_BRANCH_NONNEGATIVE = 6'h1d,
        MDX_BRANCH_NEGATIVE_LINKED = 6'h1e,
        MDX_BRANCH_NONNEGATIVE_LINKED = 6'h1f,
        MDX_TRAP_IF_SAME = 6'h20,
        MDX_TRAP_IF_SAME_IMM = 6'h21,
        MDX_TRAP_AT_LEAST = 6'h22,
        MDX_TRAP_AT_LEAST_IMM = 6'h23,
        MDX_TRAP_AT_LEAST_UNSIGNED = 6'h24,
        MDX_TRAP_AT_LEAST_IMM_UNSIGNED = 6'h25,
        MDX_TRAP_BELOW = 6'h26,
        MDX_TRAP_BELOW_IMM = 6'h27,
        MDX_TRAP_BELOW_UNSIGNED = 6'h28,
        MDX_TRAP_BELOW_IMM_UNSIGNED = 6'h29
    } mdx_op_t;

    typedef struct packed {
        mdx_op_t op;
        logic likely;
        logic [4:0] dest;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [15:0] imm;
        logic [25:0] target;
        logic [31:0] pc;
        logic [31:0] wrap_mask;
        logic [5:0] shift_count;
    } mdx_issue_t;

    typedef struct packed {
        logic wr_en;
        logic [4:0] wr_dest;
        logic [31:0] wr_data;
        logic redirect;
        logic [31:0] redirect_pc;
        logic annul_slot;
        logic trap;
    } mdx_result_t;

    typedef enum logic [1:0] {
        MDX_ST_IDLE = 2'b00,
        MDX_ST_DIV = 2'b01,
        MDX_ST_FIX = 2'b10
    } mdx_state_t;
endpackage : mdx_pkg

// ==== rtl/mdx_divider.sv ====
`timescale 1ns/1ps
`include "mdx_defines.svh"
// restoring divider, one quotient bit a cycle
module mdx_divider #(
    parameter int WIDTH = `MDX_XLEN
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic start,
    input wire logic is_signed,
    input wire logic [WIDTH-1:0] dividend,
    input wire logic [WIDTH-1:0] divisor,
    // answer
    output logic busy,
    output logic done,
    output logic [WIDTH-1:0] quotient,
    output logic [WIDTH-1:0] remainder
);
    import mdx_pkg::*;

    initial
    begin
        if (WIDTH < 2 || WIDTH > 64)
            $error("mdx_divider: unsupported WIDTH");
    end

    localparam int CW = $clog2(WIDTH + 1);
    mdx_state_t st_reg, st_next;
    logic [WIDTH-1:0] q_reg, q_next, d_reg, d_next;
    logic [WIDTH:0] r_reg, r_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic negq_reg, negq_next, negr_reg, negr_next;
    logic done_reg, done_next;
    logic [WIDTH-1:0] quot_reg, quot_next, rem_reg, rem_next;
    logic [WIDTH:0] trial;

    always_comb
    begin
        st_next = st_reg;
        q_next = q_reg;
        d_next = d_reg;
        r_next = r_reg;
        cnt_next = cnt_reg;
        negq_next = negq_reg;
        negr_next = negr_reg;
        done_next = 1'b0;
        quot_next = quot_reg;
        rem_next = rem_reg;
        trial = '0;
        case (st_reg)
            MDX_ST_IDLE:
            begin
                if (start)
                begin
                    // operands taken as magnitudes, signs fixed at the end
                    negq_next = is_signed &
                        (dividend[WIDTH-1] ^ divisor[WIDTH-1]);
                    negr_next = is_signed & dividend[WIDTH-1];
                    q_next = (is_signed && dividend[WIDTH-1]) ?
                        -dividend : dividend;
                    d_next = (is_signed && divisor[WIDTH-1]) ?
                        -divisor : divisor;
                    r_next = '0;
                    cnt_next = CW'(WIDTH);
                    st_next = MDX_ST_DIV;
                end
            end
            MDX_ST_DIV:
            begin
                trial = {r_reg[WIDTH-1:0], q_reg[WIDTH-1]} - {1'b0, d_reg};
                if (trial[WIDTH])
                begin
                    r_next = {r_reg[WIDTH-1:0], q_reg[WIDTH-1]};
                    q_next = {q_reg[WIDTH-2:0], 1'b0};
                end
                else
                begin
                    r_next = trial;
                    q_next = {q_reg[WIDTH-2:0], 1'b1};
                end
                cnt_next = cnt_reg - CW'(1);
                if (cnt_reg == CW'(1))
                    st_next = MDX_ST_FIX;
            end
            MDX_ST_FIX:
            begin
                // divide by zero leaves quotient all ones (1 for a negative signed dividend), remainder = rs
                quot_next = negq_reg ? -q_reg : q_reg;
                rem_next = negr_reg ? -r_reg[WIDTH-1:0] : r_reg[WIDTH-1:0];
                done_next = 1'b1;
                st_next = MDX_ST_IDLE;
            end
            default:
                st_next = MDX_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= MDX_ST_IDLE;
            q_reg <= '0;
            d_reg <= '0;
            r_reg <= '0;
            cnt_reg <= '0;
            negq_reg <= 1'b0;
            negr_reg <= 1'b0;
            done_reg <= 1'b0;
            quot_reg <= '0;
            rem_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            q_reg <= q_next;
            d_reg <= d_next;
            r_reg <= r_next;
            cnt_reg <= cnt_next;
            negq_reg <= negq_next;
            negr_reg <= negr_next;
            done_reg <= done_next;
            quot_reg <= quot_next;
            rem_reg <= rem_next;
        end
    end

    assign busy = (st_reg != MDX_ST_IDLE);
    assign done = done_reg;
    assign quotient = quot_reg;
    assign remainder = rem_reg;
endmodule : mdx_divider

// ==== rtl/mdx_exec.sv ====
`timescale 1ns/1ps
`include "mdx_defines.svh"
// Contract
// - signed product: full 64-bit two's complement product into upper/lower
// - unsigned product: 64-bit unsigned product into upper/lower pair
// - signed divide: quotient to lower, remainder to upper
// - unsigned divide: quotient to lower, remainder to upper
// - moves copy upper/lower to a register and back
// - circular sum: low bits under wrap mask from sum, rest from source
// - first-one scan from msb returns bit number, all ones if none
// - first-zero scan from msb returns bit number, all ones if none
// - right pair shift by count, keep least significant word
// - left pair shift by count, keep most significant word
// - multiply-accumulate adds product into the upper/lower pair
// - multiply-subtract takes product from the upper/lower pair
// - minimum and maximum compare as signed values
// - absolute jump: delay-slot pc high nibble, 26-bit field shifted two
// - absolute jump with link writes return address to r31
// - register jump to source; linking form writes dest register
// - equal and not-equal branches, likely forms same conditions
// - zero-compare branches: le, gt, lt, ge against zero
// - linked branches always write r31, branch on lt/ge zero
// - equal and at-least register traps, unsigned forms unsigned
// - immediate traps for equal and at-least, unsigned variants
// - below traps in register, immediate and unsigned forms
// - branch target is slot address plus offset shifted two
// - likely branch not taken annuls its delay slot
module mdx_exec #(
    parameter int XLEN = `MDX_XLEN
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // issue from pipeline
    input wire logic issue_valid,
    input wire mdx_pkg::mdx_issue_t issue,
    output logic issue_ready,
    // result to pipeline
    output logic res_valid,
    output mdx_pkg::mdx_result_t res,
    // result register pair view
    output logic [XLEN-1:0] upper_result_register,
    output logic [XLEN-1:0] lower_result_register
);
    import mdx_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    if (XLEN != 32)
        $error("mdx_exec: only a 32-bit datapath is supported");

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] hi_reg, hi_next, lo_reg, lo_next;
    logic rv_reg, rv_next, take;
    mdx_result_t res_reg, res_next;
    logic div_start, div_busy, div_done;
    logic [31:0] div_q, div_r;

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    logic [31:0] a, b, imm_sx, slot_pc, link_pc, br_tgt, csum;
    logic signed [63:0] prod_s;
    logic [63:0] prod_u, prod, pair, shr, shl;
    logic [5:0] one_idx, zero_idx;
    logic one_hit, zero_hit;
    logic sa_lt_z, s_eq, s_ge, u_ge, s_ge_i, u_ge_i, is_mul_signed;

    assign a = issue.src_a;
    assign b = issue.src_b;
    assign imm_sx = {{16{issue.imm[15]}}, issue.imm};
    assign slot_pc = issue.pc + 32'h0000_0004;
    assign link_pc = issue.pc + 32'h0000_0008;
    assign br_tgt = slot_pc + {imm_sx[29:0], 2'b00};
    assign is_mul_signed = (issue.op == MDX_PRODUCT_SIGNED) ||
        (issue.op == MDX_PRODUCT_ACCUMULATE_SIGNED) ||
        (issue.op == MDX_PRODUCT_DEDUCT_SIGNED);
    assign prod_s = $signed(a) * $signed(b);
    assign prod_u = {32'h0000_0000, a} * {32'h0000_0000, b};
    assign prod = is_mul_signed ? prod_s : prod_u;
    assign pair = {hi_reg, lo_reg};
    assign shr = {a, b} >> issue.shift_count;
    assign shl = {a, b} << issue.shift_count;
    assign csum = (issue.wrap_mask & (a + imm_sx)) |
        (~issue.wrap_mask & a);
    assign sa_lt_z = a[31];
    assign s_eq = (a == b);
    assign s_ge = ($signed(a) >= $signed(b));
    assign u_ge = (a >= b);
    assign s_ge_i = ($signed(a) >= $signed(imm_sx));
    assign u_ge_i = (a >= imm_sx);

    // msb-first scan: lowest index loops first, higher hits override
    always_comb
    begin
        one_idx = 6'h00;
        zero_idx = 6'h00;
        one_hit = (a != 32'h0000_0000);
        zero_hit = (a != 32'hffff_ffff);
        for (int i = 0; i < 32; i++)
        begin
            if (a[i])
                one_idx = 6'(i);
            else
                zero_idx = 6'(i);
        end
    end

    assign take = issue_valid && issue_ready;
    // stall through the done cycle too, so a pair read sees the quotient
    assign issue_ready = !div_busy && !div_done;
    assign div_start = take && ((issue.op == MDX_QUOTIENT_SIGNED) ||
        (issue.op == MDX_QUOTIENT_UNSIGNED));

    mdx_divider #(
        .WIDTH(32)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .start(div_start),
        .is_signed(issue.op == MDX_QUOTIENT_SIGNED),
        .dividend(a),
        .divisor(b),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_q),
        .remainder(div_r)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic [63:0] acc;
        logic cond;
        acc = '0;
        cond = 1'b0;
        hi_next = hi_reg;
        lo_next = lo_reg;
        rv_next = take && !div_start;
        res_next = '0;
        if (div_done)
            {hi_next, lo_next} = {div_r, div_q};
        if (take)
        begin
            case (issue.op)
                MDX_PRODUCT_SIGNED, MDX_PRODUCT_UNSIGNED:
                    {hi_next, lo_next} = prod;
                MDX_PRODUCT_ACCUMULATE_SIGNED,
                MDX_PRODUCT_ACCUMULATE_UNSIGNED:
                begin
                    acc = pair + prod;
                    {hi_next, lo_next} = acc;
                end
                MDX_PRODUCT_DEDUCT_SIGNED, MDX_PRODUCT_DEDUCT_UNSIGNED:
                begin
                    acc = pair - prod;
                    {hi_next, lo_next} = acc;
                end
                MDX_READ_UPPER_RESULT, MDX_READ_LOWER_RESULT:
                begin
                    res_next.wr_en = 1'b1;
                    res_next.wr_dest = issue.dest;
                    res_next.wr_data = (issue.op == MDX_READ_UPPER_RESULT) ?
                        hi_reg : lo_reg;
                end
                MDX_WRITE_UPPER_RESULT:
                    hi_next = a;
                MDX_WRITE_LOWER_RESULT:
                    lo_next = a;
                MDX_CIRCULAR_IMMEDIATE_SUM, MDX_FIRST_ONE_SCAN,
                MDX_FIRST_ZERO_SCAN, MDX_PAIR_SHIFT_TOWARD_LSB,
                MDX_PAIR_SHIFT_TOWARD_MSB, MDX_MINIMUM, MDX_MAXIMUM:
                begin
                    res_next.wr_en = 1'b1;
                    res_next.wr_dest = issue.dest;
                    case (issue.op)
                        MDX_CIRCULAR_IMMEDIATE_SUM:
                            res_next.wr_data = csum;
                        MDX_FIRST_ONE_SCAN:
                            res_next.wr_data = one_hit ?
                                {26'h0, one_idx} : 32'hffff_ffff;
                        MDX_FIRST_ZERO_SCAN:
                            res_next.wr_data = zero_hit ?
                                {26'h0, zero_idx} : 32'hffff_ffff;
                        MDX_PAIR_SHIFT_TOWARD_LSB:
                            res_next.wr_data = shr[31:0];
                        MDX_PAIR_SHIFT_TOWARD_MSB:
                            res_next.wr_data = shl[63:32];
                        MDX_MINIMUM:
                            res_next.wr_data = s_ge ? b : a;
                        default:
                            res_next.wr_data = s_ge ? a : b;
                    endcase
                end
                MDX_ABSOLUTE_TRANSFER, MDX_ABSOLUTE_TRANSFER_WITH_LINK:
                begin
                    res_next.redirect = 1'b1;
                    res_next.redirect_pc =
                        {slot_pc[31:28], issue.target, 2'b00};
                    if (issue.op == MDX_ABSOLUTE_TRANSFER_WITH_LINK)
                    begin
                        res_next.wr_en = 1'b1;
                        res_next.wr_dest = `MDX_LINK_REG;
                        res_next.wr_data = link_pc;
                    end
                end
                MDX_REGISTER_TARGET_TRANSFER, MDX_REGISTER_TRANSFER_WITH_LINK:
                begin
                    res_next.redirect = 1'b1;
                    res_next.redirect_pc = a;
                    res_next.wr_en =
                        (issue.op == MDX_REGISTER_TRANSFER_WITH_LINK);
                    res_next.wr_dest = issue.dest;
                    res_next.wr_data = link_pc;
                end
                MDX_BRANCH_IF_SAME, MDX_BRANCH_IF_DIFFERENT,
                MDX_BRANCH_NONPOSITIVE, MDX_BRANCH_POSITIVE,
                MDX_BRANCH_NEGATIVE, MDX_BRANCH_NONNEGATIVE,
                MDX_BRANCH_NEGATIVE_LINKED, MDX_BRANCH_NONNEGATIVE_LINKED:
                begin
                    case (issue.op)
                        MDX_BRANCH_IF_SAME: cond = s_eq;
                        MDX_BRANCH_IF_DIFFERENT: cond = !s_eq;
                        MDX_BRANCH_NONPOSITIVE:
                            cond = sa_lt_z || (a == 32'h0);
                        MDX_BRANCH_POSITIVE:
                            cond = !sa_lt_z && (a != 32'h0);
                        MDX_BRANCH_NEGATIVE,
                        MDX_BRANCH_NEGATIVE_LINKED: cond = sa_lt_z;
                        default: cond = !sa_lt_z;
                    endcase
                    res_next.redirect = cond;
                    res_next.redirect_pc = br_tgt;
                    res_next.annul_slot = issue.likely && !cond;
                    if (issue.op == MDX_BRANCH_NEGATIVE_LINKED ||
                        issue.op == MDX_BRANCH_NONNEGATIVE_LINKED)
                    begin
                        res_next.wr_en = 1'b1;
                        res_next.wr_dest = `MDX_LINK_REG;
                        res_next.wr_data = link_pc;
                    end
                end
                MDX_TRAP_IF_SAME: res_next.trap = s_eq;
                MDX_TRAP_AT_LEAST: res_next.trap = s_ge;
                MDX_TRAP_AT_LEAST_UNSIGNED: res_next.trap = u_ge;
                MDX_TRAP_IF_SAME_IMM: res_next.trap = (a == imm_sx);
                MDX_TRAP_AT_LEAST_IMM: res_next.trap = s_ge_i;
                MDX_TRAP_AT_LEAST_IMM_UNSIGNED: res_next.trap = u_ge_i;
                MDX_TRAP_BELOW: res_next.trap = !s_ge;
                MDX_TRAP_BELOW_UNSIGNED: res_next.trap = !u_ge;
                MDX_TRAP_BELOW_IMM: res_next.trap = !s_ge_i;
                MDX_TRAP_BELOW_IMM_UNSIGNED: res_next.trap = !u_ge_i;
                default:
                    res_next = '0;
            endcase
        end
        if (res_next.trap)
        begin
            // a trap leaves no architectural trace
            res_next.wr_en = 1'b0;
            res_next.redirect = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hi_reg <= `MDX_HI_RST;
            lo_reg <= `MDX_LO_RST;
            rv_reg <= 1'b0;
            res_reg <= '0;
        end
        else
        begin
            hi_reg <= hi_next;
            lo_reg <= lo_next;
            rv_reg <= rv_next || div_done;
            res_reg <= res_next;
        end
    end

    assign res_valid = rv_reg;
    assign res = res_reg;
    assign upper_result_register = hi_reg;
    assign lower_result_register = lo_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_prod_u;
        take && issue.op == MDX_PRODUCT_UNSIGNED |=>
            {hi_reg, lo_reg} == $past(a) * $past(b);
    endproperty
    a_prod_u: assert property (p_prod_u) else $error("unsigned product");
    property p_div_time;
        div_start |-> ##[33:34] div_done;
    endproperty
    a_div_time: assert property (p_div_time) else $error("divide late");
    property p_trap_quiet;
        res_valid && res.trap |-> !res.wr_en && !res.redirect;
    endproperty
    a_trap_quiet: assert property (p_trap_quiet) else $error("trap");
    property p_annul;
        res_valid && res.annul_slot |-> !res.redirect;
    endproperty
    a_annul: assert property (p_annul) else $error("annul on taken");
    property p_scan;
        take && issue.op == MDX_FIRST_ONE_SCAN && a != 32'h0 |=>
            res.wr_data[31:6] == 26'h0 && $past(a) >> res.wr_data == 32'h1;
    endproperty
    a_scan: assert property (p_scan) else $error("scan index");
    property p_link;
        take && issue.op == MDX_ABSOLUTE_TRANSFER_WITH_LINK |=>
            res.wr_en && res.wr_dest == 5'h1f &&
            res.wr_data == $past(issue.pc) + 32'h8;
    endproperty
    a_link: assert property (p_link) else $error("link value");
    property p_min;
        take && issue.op == MDX_MINIMUM |=>
            $signed(res.wr_data) <= $signed($past(a)) &&
            $signed(res.wr_data) <= $signed($past(b));
    endproperty
    a_min: assert property (p_min) else $error("minimum");
    property p_stall;
        div_start |=> !issue_ready [*8];
    endproperty
    a_stall: assert property (p_stall) else $error("no stall");
    c_div: cover property (div_done);
    c_trap: cover property (res_valid && res.trap);
    c_annul: cover property (res_valid && res.annul_slot);
endmodule : mdx_exec

// ==== tb/mdx_pipe_model.sv ====
`timescale 1ns/1ps
// pipeline side: offers one op, holds it until the block takes it
module mdx_pipe_model
    import mdx_pkg::*;
(
    // handshake
    input wire logic clk,
    input wire logic issue_ready,
    output logic issue_valid,
    output mdx_pkg::mdx_issue_t issue
);
    initial
    begin
        issue_valid = 1'b0;
        issue = '0;
    end
    task automatic send(input mdx_issue_t i);
        @(negedge clk);
        issue_valid = 1'b1;
        issue = i;
        while (issue_ready !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        issue_valid = 1'b0;
        // released fields must not keep looking valid
        issue = mdx_issue_t'(~i);
    endtask : send
endmodule : mdx_pipe_model

// ==== tb/test_muldiv_branch_trap_exec.sv ====
`timescale 1ns/1ps
module test_muldiv_branch_trap_exec;
    import mdx_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issue_valid, issue_ready, res_valid;
    mdx_issue_t issue;
    mdx_result_t res;
    logic [31:0] upper, lower;
    logic [63:0] pair_exp = '0;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    initial
    begin
        forever #5 clk = ~clk;
    end
    mdx_exec uut (.clk(clk), .rst(rst), .issue_valid(issue_valid),
        .issue(issue), .issue_ready(issue_ready), .res_valid(res_valid),
        .res(res), .upper_result_register(upper),
        .lower_result_register(lower));
    mdx_pipe_model pipe (.clk(clk), .issue_ready(issue_ready),
        .issue_valid(issue_valid), .issue(issue));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic mdx_result_t norm(input mdx_result_t r);
        if (!r.wr_en)
            {r.wr_dest, r.wr_data} = '0;
        if (!r.redirect)
            r.redirect_pc = '0;
        return r;
    endfunction : norm
    function automatic mdx_result_t expect_op(input mdx_issue_t i);
        mdx_result_t r;
        logic [31:0] a, b, sx, slot;
        logic [63:0] p;
        logic c;
        {r, a, b, c} = {73'h0, i.src_a, i.src_b, 1'b0};
        sx = {{16{i.imm[15]}}, i.imm};
        slot = i.pc + 32'h4;
        p = {32'h0, a} * {32'h0, b};
        if (i.op inside {MDX_PRODUCT_SIGNED, MDX_PRODUCT_ACCUMULATE_SIGNED,
            MDX_PRODUCT_DEDUCT_SIGNED})
            p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
        r.wr_dest = i.dest;
        r.wr_data = 32'hffff_ffff;
        case (i.op)
        MDX_PRODUCT_SIGNED, MDX_PRODUCT_UNSIGNED: pair_exp = p;
        MDX_PRODUCT_ACCUMULATE_SIGNED, MDX_PRODUCT_ACCUMULATE_UNSIGNED:
            pair_exp = pair_exp + p;
        MDX_PRODUCT_DEDUCT_SIGNED, MDX_PRODUCT_DEDUCT_UNSIGNED:
            pair_exp = pair_exp - p;
        MDX_QUOTIENT_SIGNED: pair_exp = {32'($signed(a) % $signed(b)),
            32'($signed(a) / $signed(b))};
        MDX_QUOTIENT_UNSIGNED: pair_exp = {a % b, a / b};
        MDX_READ_UPPER_RESULT: r.wr_data = pair_exp[63:32];
        MDX_READ_LOWER_RESULT: r.wr_data = pair_exp[31:0];
        MDX_WRITE_UPPER_RESULT: pair_exp[63:32] = a;
        MDX_WRITE_LOWER_RESULT: pair_exp[31:0] = a;
        MDX_CIRCULAR_IMMEDIATE_SUM:
            r.wr_data = (a & ~i.wrap_mask) | ((a + sx) & i.wrap_mask);
        MDX_FIRST_ONE_SCAN, MDX_FIRST_ZERO_SCAN:
            for (int k = 0; k < 32; k++)
                if (a[k] ^ (i.op == MDX_FIRST_ZERO_SCAN))
                    r.wr_data = k;
        MDX_PAIR_SHIFT_TOWARD_LSB: r.wr_data = 32'({a, b} >> i.shift_count);
        MDX_PAIR_SHIFT_TOWARD_MSB:
            r.wr_data = 32'(({a, b} << i.shift_count) >> 32);
        MDX_MINIMUM: r.wr_data = ($signed(a) < $signed(b)) ? a : b;
        MDX_MAXIMUM: r.wr_data = ($signed(a) < $signed(b)) ? b : a;
        MDX_ABSOLUTE_TRANSFER, MDX_ABSOLUTE_TRANSFER_WITH_LINK:
            {r.redirect, r.redirect_pc} = {1'b1, slot[31:28], i.target, 2'b00};
        MDX_REGISTER_TARGET_TRANSFER, MDX_REGISTER_TRANSFER_WITH_LINK:
            {r.redirect, r.redirect_pc} = {1'b1, a};
        MDX_BRANCH_IF_SAME, MDX_TRAP_IF_SAME: c = a == b;
        MDX_BRANCH_IF_DIFFERENT: c = a != b;
        MDX_BRANCH_NONPOSITIVE: c = a[31] || a == 0;
        MDX_BRANCH_POSITIVE: c = !a[31] && a != 0;
        MDX_BRANCH_NEGATIVE, MDX_BRANCH_NEGATIVE_LINKED: c = a[31];
        MDX_BRANCH_NONNEGATIVE, MDX_BRANCH_NONNEGATIVE_LINKED: c = !a[31];
        MDX_TRAP_IF_SAME_IMM: c = a == sx;
        MDX_TRAP_AT_LEAST: c = $signed(a) >= $signed(b);
        MDX_TRAP_AT_LEAST_IMM: c = $signed(a) >= $signed(sx);
        MDX_TRAP_AT_LEAST_UNSIGNED: c = a >= b;
        MDX_TRAP_AT_LEAST_IMM_UNSIGNED: c = a >= sx;
        MDX_TRAP_BELOW: c = $signed(a) < $signed(b);
        MDX_TRAP_BELOW_IMM: c = $signed(a) < $signed(sx);
        MDX_TRAP_BELOW_UNSIGNED: c = a < b;
        MDX_TRAP_BELOW_IMM_UNSIGNED: c = a < sx;
        default: ;
        endcase
        r.wr_en = i.op inside {[MDX_READ_UPPER_RESULT:MDX_READ_LOWER_RESULT],
            [MDX_CIRCULAR_IMMEDIATE_SUM:MDX_PAIR_SHIFT_TOWARD_MSB],
            MDX_MINIMUM, MDX_MAXIMUM, MDX_REGISTER_TRANSFER_WITH_LINK};
        if (i.op inside {[MDX_BRANCH_IF_SAME:MDX_BRANCH_NONNEGATIVE_LINKED]})
            {r.redirect, r.redirect_pc, r.annul_slot} =
                {c, slot + (sx << 2), i.likely & ~c};
        if (i.op inside {MDX_ABSOLUTE_TRANSFER_WITH_LINK,
            MDX_BRANCH_NEGATIVE_LINKED, MDX_BRANCH_NONNEGATIVE_LINKED})
            r.wr_dest = 5'h1f;
        if (i.op inside {MDX_ABSOLUTE_TRANSFER_WITH_LINK,
            MDX_REGISTER_TRANSFER_WITH_LINK, MDX_BRANCH_NEGATIVE_LINKED,
            MDX_BRANCH_NONNEGATIVE_LINKED})
            {r.wr_en, r.wr_data} = {1'b1, i.pc + 32'h8};
        if (i.op >= MDX_TRAP_IF_SAME)
            r.trap = c;
        return r;
    endfunction : expect_op
    // first 42 calls walk every opcode once; corners mixed into operands
    function automatic mdx_issue_t rand_op(input int k);
        mdx_issue_t i;
        i = '0;
        i.op = mdx_op_t'((k < 42) ? k : $urandom_range(41));
        {i.src_a, i.src_b, i.pc, i.wrap_mask} =
            {$urandom, $urandom, $urandom, $urandom};
        {i.imm, i.target, i.shift_count, i.likely, i.dest} =
            54'({$urandom, $urandom});
        case ($urandom_range(7))
        0: i.src_b = i.src_a;
        1: i.src_a = {{16{i.imm[15]}}, i.imm};
        2: i.src_a = '0;
        3: i.src_a = '1;
        4: i.shift_count = {6{i.src_a[0]}};
        default: ;
        endcase
        // divide by zero and signed overflow left out of the random mix
        if (i.op inside {MDX_QUOTIENT_SIGNED, MDX_QUOTIENT_UNSIGNED} &&
            (i.src_b == '0 || i.src_b == '1))
            i.src_b = 32'h3;
        return i;
    endfunction : rand_op
    task automatic run(input mdx_issue_t i);
        mdx_result_t e;
        int n;
        e = expect_op(i);
        pipe.send(i);
        n = 0;
        while (res_valid !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk(norm(res), norm(e));
        chk({upper, lower}, pair_exp);
    endtask : run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    initial
    begin
        void'($urandom(32'h27f1));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk({upper, lower, res_valid, issue_ready}, {64'h0, 2'b01});
        $display("reset test done");
        for (int k = 0; k < 42; k++)
            run(rand_op(k));
        for (int k = 42; k < 600; k++)
            run(rand_op(k));
        $display("random op test done");
        end_of_test();
    end
endmodule : test_muldiv_branch_trap_exec
